//--- sgrb_bank.sv
/*
 * sgrb_bank: byte-addressed management register bank for the switch,
 * global operation control registers included.
 * assumes: a serial or in-band front end presents single-cycle byte
 * requests on mclk; interrupt sources are async levels from other blocks.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] full register space open to serial and in-band management, not clause-22
// [R2] 16-bit address splits into port, page and register index fields
// [R3] port zero selects global registers, one to seven select ports
// [R4] address bit fifteen is always zero; decode ignores it
// [R5] every byte is individually readable and writable in any order
// [R6] multi-byte registers are big-endian, MSB at the lowest address
// [R7] global space has six 256-byte groups; 0x0600-0x0fff reserved
// [R8] port pages 2, 7 and d-f are reserved
// [R9] host never writes reserved regions
// [R10] host read-modify-writes registers with reserved bits
// [R11] first three global bytes are read-only identification
// [R12] fourth byte upper nibble is revision; bits three to one reserved
// [R13] bit zero of fourth byte pulses data-path reset and self-clears
// [R14] wake pin is driven only while its output enable bit is set
// [R15] wake pin polarity bit: zero active low, one active high
// [R16] 32-bit top interrupt status summarises lookup and gpio sources
// [R17] status bit 31 lookup engine, bit 30 gpio trigger/timestamp
// [R18] mask register: zero enables, one disables, resets to zero
// [R19] unimplemented or reserved reads return zero without side effects
// [R20] status bits follow sources; reading the summary clears nothing
module sgrb_bank (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // management byte access (serial or in-band front end)
  input  wire sgrb_pkg::sgrb_req_s mgmt_req,
  output logic                     mgmt_rvalid,
  output logic [7:0]               mgmt_rdata,
  // other register pages outside the operation control group
  output logic                     ext_wr,
  output logic                     ext_rd,
  output logic [15:0]              ext_addr,
  output logic [7:0]               ext_wdata,
  input  wire logic [7:0]          ext_rdata,
  // data-path reset pulse
  output logic                     datapath_rst,
  // interrupt sources (asynchronous levels) and pending summary
  input  wire logic                lookup_engine_irq,
  input  wire logic                gpio_ts_irq,
  output logic                     irq_pending,
  // wake-event pin
  output logic                     wake_event_pin_o,
  output logic                     wake_event_pin_oe,
  input  wire logic                wake_event
);
  logic                 rst_n;
  sgrb_pkg::sgrb_dec_s  dec;

  sgrb_reset_sync u_rst (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .rst_sync_n (rst_n)
  );

  sgrb_addr_decode u_dec (
    .addr (mgmt_req.addr),
    .dec  (dec)
  );

  // source synchronisers: second stage alone is read by logic
  logic [1:0]  irq_s1_r;
  logic [1:0]  irq_s1_nxt;
  logic [1:0]  irq_s2_r;
  logic [1:0]  irq_s2_nxt;
  logic        wake_s1_r;
  logic        wake_s1_nxt;
  logic        wake_s2_r;
  logic        wake_s2_nxt;

  // register state
  logic        soft_rst_r;
  logic        soft_rst_nxt;
  logic        wake_oe_r;
  logic        wake_oe_nxt;
  logic        wake_pol_r;
  logic        wake_pol_nxt;
  logic [1:0]  irq_mask_r;
  logic [1:0]  irq_mask_nxt;
  logic [31:0] irq_stat_w;

  // outputs
  logic       rvalid_nxt;
  logic [7:0] rdata_nxt;
  logic       ext_wr_nxt;
  logic       ext_rd_nxt;
  logic [15:0] ext_addr_nxt;
  logic [7:0] ext_wdata_nxt;
  logic       irq_pend_nxt;
  logic       pin_o_nxt;
  logic       pin_oe_nxt;
  logic       ext_pending_r;
  logic       ext_pending_nxt;

  // byte lane of a big-endian word: lane 0 is bits 31:24
  function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = w[31 - 8*lane -: 8]; // [R6]
    return b;
  endfunction

  // true when idx falls on one of the four bytes of the word at base
  function automatic logic in_word(input logic [7:0] idx, input logic [7:0] base);
    logic hit;
    hit = (idx >= base) && (idx <= base + 8'h03);
    return hit;
  endfunction

  function automatic logic [31:0] mask_word(input logic [1:0] m);
    logic [31:0] w;
    w = sgrb_pkg::WORD_ZERO;
    w[sgrb_pkg::IRQ_LOOKUP_BIT] = m[1];
    w[sgrb_pkg::IRQ_GPIO_BIT]   = m[0];
    return w;
  endfunction

  logic oper_hit;
  logic ext_hit;
  assign oper_hit = (dec.region == sgrb_pkg::SGRB_REGION_OPER);
  assign ext_hit  = (dec.region == sgrb_pkg::SGRB_REGION_OTHER);

  // status follows synchronised sources directly, no latching [R20] [R17]
  always_comb begin
    irq_stat_w = sgrb_pkg::WORD_ZERO;
    irq_stat_w[sgrb_pkg::IRQ_LOOKUP_BIT] = irq_s2_r[1];
    irq_stat_w[sgrb_pkg::IRQ_GPIO_BIT]   = irq_s2_r[0]; // [R16]
  end

  // synchroniser stages: plain shift, nothing reads stage one but stage two
  always_comb begin
    irq_s1_nxt  = {lookup_engine_irq, gpio_ts_irq};
    irq_s2_nxt  = irq_s1_r;
    wake_s1_nxt = wake_event;
    wake_s2_nxt = wake_s1_r;
  end

  // register and access path
  always_comb begin
    soft_rst_nxt  = 1'b0; // [R13] self-clearing
    wake_oe_nxt   = wake_oe_r;
    wake_pol_nxt  = wake_pol_r;
    irq_mask_nxt  = irq_mask_r;
    rvalid_nxt    = 1'b0;
    rdata_nxt     = mgmt_rdata;
    ext_wr_nxt    = 1'b0;
    ext_rd_nxt    = 1'b0;
    ext_addr_nxt  = ext_addr;
    ext_wdata_nxt = ext_wdata;
    ext_pending_nxt = 1'b0;

    // byte writes, each byte standing alone [R5] [R1]
    if (mgmt_req.wr) begin
      if (oper_hit) begin
        case (dec.index)
          sgrb_pkg::IDX_REV_RST: begin
            soft_rst_nxt = mgmt_req.wdata[sgrb_pkg::SOFT_RST_BIT]; // [R13]
          end
          sgrb_pkg::IDX_WAKE_CTL: begin
            wake_oe_nxt  = mgmt_req.wdata[sgrb_pkg::WAKE_OE_BIT]; // [R14]
            wake_pol_nxt = mgmt_req.wdata[sgrb_pkg::WAKE_POL_BIT]; // [R15]
          end
          sgrb_pkg::IDX_IRQ_MASK0: begin
            irq_mask_nxt[1] = mgmt_req.wdata[sgrb_pkg::IRQ_LOOKUP_BIT - 24]; // [R18]
            irq_mask_nxt[0] = mgmt_req.wdata[sgrb_pkg::IRQ_GPIO_BIT - 24];
          end
          default: begin
            // identification and reserved bytes ignore writes [R11]
          end
        endcase
      end else if (ext_hit) begin
        ext_wr_nxt    = 1'b1;
        ext_addr_nxt  = mgmt_req.addr;
        ext_wdata_nxt = mgmt_req.wdata;
      end
      // reserved regions: host must not write; dropped here [R9]
    end else if (mgmt_req.rd) begin
      if (oper_hit) begin
        rvalid_nxt = 1'b1;
        case (dec.index)
          sgrb_pkg::IDX_IDENT0: rdata_nxt = sgrb_pkg::IDENT_FIXED_DEF; // [R11]
          sgrb_pkg::IDX_IDENT1: rdata_nxt = sgrb_pkg::IDENT_UPPER_DEF;
          sgrb_pkg::IDX_IDENT2: rdata_nxt = sgrb_pkg::IDENT_LOWER_DEF;
          sgrb_pkg::IDX_REV_RST: begin
            // reserved bits and self-clearing bit read zero [R12]
            rdata_nxt = {sgrb_pkg::REVISION_DEF, 4'h0};
          end
          sgrb_pkg::IDX_WAKE_CTL: begin
            rdata_nxt = {6'h00, wake_oe_r, wake_pol_r};
          end
          default: begin
            if (in_word(dec.index, sgrb_pkg::IDX_IRQ_STAT0)) begin
              rdata_nxt = be_byte(irq_stat_w, dec.index[1:0]); // [R6] [R20]
            end else if (in_word(dec.index, sgrb_pkg::IDX_IRQ_MASK0)) begin
              rdata_nxt = be_byte(mask_word(irq_mask_r), dec.index[1:0]);
            end else begin
              rdata_nxt = sgrb_pkg::BYTE_ZERO; // [R19]
            end
          end
        endcase
      end else if (ext_hit) begin
        ext_rd_nxt      = 1'b1;
        ext_addr_nxt    = mgmt_req.addr;
        ext_pending_nxt = 1'b1;
      end else begin
        rvalid_nxt = 1'b1;
        rdata_nxt  = sgrb_pkg::BYTE_ZERO; // [R19]
      end
    end

    // external read answers one cycle after the strobe
    // a local read in this cycle would be lost; hosts space reads after it
    if (ext_pending_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = ext_rdata;
    end
  end

  // interrupt summary and wake pin outputs
  always_comb begin
    // zero in the mask enables the source [R18]
    irq_pend_nxt = |(irq_s2_r & ~irq_mask_r);

    // wake pin: polarity applied, driven only when enabled [R14] [R15]
    pin_oe_nxt = wake_oe_r;
    pin_o_nxt  = wake_pol_r ? wake_s2_r : ~wake_s2_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_r          <= 2'h0;
      irq_s2_r          <= 2'h0;
      wake_s1_r         <= 1'b0;
      wake_s2_r         <= 1'b0;
      soft_rst_r        <= 1'b0;
      wake_oe_r         <= 1'b0;
      wake_pol_r        <= 1'b0;
      irq_mask_r        <= 2'h0;
      ext_pending_r     <= 1'b0;
      mgmt_rvalid       <= 1'b0;
      mgmt_rdata        <= 8'h00;
      ext_wr            <= 1'b0;
      ext_rd            <= 1'b0;
      ext_addr          <= 16'h0000;
      ext_wdata         <= 8'h00;
      irq_pending       <= 1'b0;
      wake_event_pin_o  <= 1'b1;
      wake_event_pin_oe <= 1'b0;
    end else begin
      irq_s1_r          <= irq_s1_nxt;
      irq_s2_r          <= irq_s2_nxt;
      wake_s1_r         <= wake_s1_nxt;
      wake_s2_r         <= wake_s2_nxt;
      soft_rst_r        <= soft_rst_nxt;
      wake_oe_r         <= wake_oe_nxt;
      wake_pol_r        <= wake_pol_nxt;
      irq_mask_r        <= irq_mask_nxt;
      ext_pending_r     <= ext_pending_nxt;
      mgmt_rvalid       <= rvalid_nxt;
      mgmt_rdata        <= rdata_nxt;
      ext_wr            <= ext_wr_nxt;
      ext_rd            <= ext_rd_nxt;
      ext_addr          <= ext_addr_nxt;
      ext_wdata         <= ext_wdata_nxt;
      irq_pending       <= irq_pend_nxt;
      wake_event_pin_o  <= pin_o_nxt;
      wake_event_pin_oe <= pin_oe_nxt;
    end
  end

  assign datapath_rst = soft_rst_r; // [R13] one-cycle pulse, registers untouched
endmodule
`default_nettype wire

//--- sgrb_pkg.sv
/*
 * sgrb_pkg: constants and carrier types for the switch global register bank.
 * assumes: byte-wide management accesses from a serial or in-band front end.
 */
package sgrb_pkg;
  // address fields
  localparam int ADDR_W        = 16;
  localparam int PORT_HI       = 14;
  localparam int PORT_LO       = 12;
  localparam int PAGE_HI       = 11;
  localparam int PAGE_LO       = 8;
  localparam int IDX_HI        = 7;
  localparam int IDX_LO        = 0;
  localparam logic [2:0] PORT_GLOBAL = 3'h0;
  localparam logic [2:0] PORT_MAX    = 3'h7;
  // global pages
  localparam logic [3:0] GPAGE_OPER  = 4'h0;
  localparam logic [3:0] GPAGE_LAST  = 4'h5;
  // port pages that are reserved
  localparam logic [3:0] PPAGE_RSV_A = 4'h2;
  localparam logic [3:0] PPAGE_RSV_B = 4'h7;
  localparam logic [3:0] PPAGE_RSV_C = 4'hd;
  // register indices within the operation control page
  localparam logic [7:0] IDX_IDENT0     = 8'h00;
  localparam logic [7:0] IDX_IDENT1     = 8'h01;
  localparam logic [7:0] IDX_IDENT2     = 8'h02;
  localparam logic [7:0] IDX_REV_RST    = 8'h03;
  localparam logic [7:0] IDX_WAKE_CTL   = 8'h06;
  localparam logic [7:0] IDX_IRQ_STAT0  = 8'h10;
  localparam logic [7:0] IDX_IRQ_STAT3  = 8'h13;
  localparam logic [7:0] IDX_IRQ_MASK0  = 8'h14;
  // field positions
  localparam int REV_HI         = 7;
  localparam int REV_LO         = 4;
  localparam int SOFT_RST_BIT   = 0;
  localparam int WAKE_OE_BIT    = 1;
  localparam int WAKE_POL_BIT   = 0;
  localparam int IRQ_LOOKUP_BIT = 31;
  localparam int IRQ_GPIO_BIT   = 30;
  // identity values: arbitrary neutral values
  localparam logic [7:0] IDENT_FIXED_DEF = 8'h5a;
  localparam logic [7:0] IDENT_UPPER_DEF = 8'h12;
  localparam logic [7:0] IDENT_LOWER_DEF = 8'h34;
  localparam logic [3:0] REVISION_DEF    = 4'h1;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

  typedef enum logic [1:0] {
    SGRB_REGION_OPER,
    SGRB_REGION_OTHER,
    SGRB_REGION_RESERVED
  } sgrb_region_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sgrb_req_s;

  typedef struct packed {
    logic [2:0]   port;
    logic [3:0]   page;
    logic [7:0]   index;
    sgrb_region_e region;
  } sgrb_dec_s;
endpackage

//--- sgrb_addr_decode.sv
/*
 * sgrb_addr_decode: splits a byte address into port, page and index fields
 * and classifies the region. assumes: purely combinational use by the bank.
 */
`timescale 1ns/100ps
`default_nettype none
module sgrb_addr_decode (
  // address in
  input  wire logic [15:0]        addr,
  // decoded fields
  output sgrb_pkg::sgrb_dec_s     dec
);
  function automatic sgrb_pkg::sgrb_region_e classify(input logic [2:0] port,
                                                      input logic [3:0] page);
    sgrb_pkg::sgrb_region_e r;
    r = sgrb_pkg::SGRB_REGION_OTHER;
    if (port == sgrb_pkg::PORT_GLOBAL) begin // [R3]
      if (page == sgrb_pkg::GPAGE_OPER) begin
        r = sgrb_pkg::SGRB_REGION_OPER;
      end else if (page > sgrb_pkg::GPAGE_LAST) begin // [R7]
        r = sgrb_pkg::SGRB_REGION_RESERVED;
      end
    end else if (page == sgrb_pkg::PPAGE_RSV_A || page == sgrb_pkg::PPAGE_RSV_B ||
                 page >= sgrb_pkg::PPAGE_RSV_C) begin // [R8]
      r = sgrb_pkg::SGRB_REGION_RESERVED;
    end
    return r;
  endfunction

  always_comb begin
    // bit 15 is assumed clear and not looked at [R4]
    dec.port   = addr[sgrb_pkg::PORT_HI:sgrb_pkg::PORT_LO]; // [R2]
    dec.page   = addr[sgrb_pkg::PAGE_HI:sgrb_pkg::PAGE_LO];
    dec.index  = addr[sgrb_pkg::IDX_HI:sgrb_pkg::IDX_LO];
    dec.region = classify(dec.port, dec.page);
  end
endmodule
`default_nettype wire

//--- sgrb_reset_sync.sv
/*
 * sgrb_reset_sync: two-stage synchroniser for the asynchronous reset.
 * assumes: reset_n may fall at any time; release is made synchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module sgrb_reset_sync (
  // clock and raw reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // synchronised reset
  output logic      rst_sync_n
);
  logic stage1_r;
  logic stage1_nxt;
  logic stage2_nxt;

  always_comb begin
    stage1_nxt = 1'b1;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage1_r   <= stage1_nxt;
      rst_sync_n <= stage2_nxt;
    end
  end
endmodule
`default_nettype wire

//--- sgrb_bank_monitor.sv
/*
 * sgrb_bank_monitor: port-level checker for the switch global register bank.
 * assumes: bound to sgrb_bank; sees its ports only, one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module sgrb_bank_monitor (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire sgrb_pkg::sgrb_req_s mgmt_req,
  input wire logic                mgmt_rvalid,
  input wire logic [7:0]          mgmt_rdata,
  input wire logic                ext_wr,
  input wire logic                ext_rd,
  input wire logic [15:0]         ext_addr,
  input wire logic [7:0]          ext_rdata,
  input wire logic                datapath_rst,
  input wire logic                lookup_engine_irq,
  input wire logic                gpio_ts_irq,
  input wire logic                irq_pending,
  input wire logic                wake_event_pin_o,
  input wire logic                wake_event_pin_oe,
  input wire logic                wake_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [14:0] a;
  logic        rdq;
  logic        rsv;
  logic        pol_r;
  assign a   = mgmt_req.addr[14:0];
  assign rdq = mgmt_req.rd & ~mgmt_req.wr;
  assign rsv = (a[14:12] == 3'h0) ? (a[11:8] > 4'h5) :
               (a[11:8] == 4'h2 || a[11:8] == 4'h7 || a[11:8] >= 4'hd);
  // shadow of the polarity bit, so the pin level can be predicted
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) pol_r <= 1'b0;
    else if (mgmt_req.wr && a == 15'h0006) pol_r <= mgmt_req.wdata[0];
  end
  sequence s_rst_pulse;
    datapath_rst ##1 !datapath_rst;
  endsequence
  sequence s_ext_answer;
    ext_rd && ext_addr[14:0] == $past(a) ##1 mgmt_rvalid && mgmt_rdata == $past(ext_rdata);
  endsequence
  property p_ident;
    rdq && a == 15'h0001 |=> mgmt_rvalid && mgmt_rdata == sgrb_pkg::IDENT_UPPER_DEF;
  endproperty
  property p_rsv_rd;
    rdq && rsv |=> mgmt_rvalid && mgmt_rdata == 8'h00;
  endproperty
  property p_rsv_fwd;
    rsv |=> !ext_wr && !ext_rd;
  endproperty
  property p_ext_rd;
    rdq && a[14:8] != 7'h00 && !rsv |=> s_ext_answer;
  endproperty
  property p_soft_rst;
    mgmt_req.wr && a == 15'h0003 && mgmt_req.wdata[0] |=> s_rst_pulse;
  endproperty
  property p_rst_cause;
    $rose(datapath_rst) |-> $past(mgmt_req.wr && a == 15'h0003);
  endproperty
  property p_oe;
    // enable bit lands one edge after the write, the pin flop one edge later
    mgmt_req.wr && a == 15'h0006 |=> ##1 wake_event_pin_oe == $past(mgmt_req.wdata[1], 2);
  endproperty
  property p_irq;
    $rose(irq_pending) |-> $past(lookup_engine_irq | gpio_ts_irq, 3);
  endproperty
  property p_wake;
    ($stable(wake_event) && $stable(pol_r)) [*4] |-> wake_event_pin_o == (wake_event ~^ pol_r);
  endproperty
  a_ident:     assert property (p_ident) else $error("ident read wrong");
  a_rsv_rd:    assert property (p_rsv_rd) else $error("reserved read not zero");
  a_rsv_fwd:   assert property (p_rsv_fwd) else $error("reserved access forwarded");
  a_ext_rd:    assert property (p_ext_rd) else $error("page read path wrong");
  a_soft_rst:  assert property (p_soft_rst) else $error("no reset pulse");
  a_rst_cause: assert property (p_rst_cause) else $error("stray reset pulse");
  a_oe:        assert property (p_oe) else $error("pin enable wrong");
  a_irq:       assert property (p_irq) else $error("pending without source");
  a_wake:      assert property (p_wake) else $error("pin level wrong");
endmodule
bind sgrb_bank sgrb_bank_monitor u_mon (.mclk, .reset_n, .mgmt_req, .mgmt_rvalid, .mgmt_rdata,
  .ext_wr, .ext_rd, .ext_addr, .ext_rdata, .datapath_rst, .lookup_engine_irq, .gpio_ts_irq,
  .irq_pending, .wake_event_pin_o, .wake_event_pin_oe, .wake_event);
`default_nettype wire

//--- sgrb_page_model.sv
/*
 * sgrb_page_model: byte store standing in for the register pages outside
 * the operation page. assumes: ext_rdata is sampled while ext_rd is high.
 */
`timescale 1ns/100ps
`default_nettype none
module sgrb_page_model (
  // clock
  input  wire logic        mclk,
  // forwarded page access
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  output logic      [7:0]  ext_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge mclk) begin
    if (ext_wr) mem[ext_addr[7:0]] <= ext_wdata;
    if (ext_rd) last_r <= mem[ext_addr[7:0]];
  end
  // off-cycle bus shows the inverse, so a late sample cannot pass
  assign ext_rdata = ext_rd ? mem[ext_addr[7:0]] : ~last_r;
endmodule
`default_nettype wire

//--- switch_global_register_bank_tb.sv
/*
 * switch_global_register_bank_tb: byte-access tests of the register bank.
 * assumes: sgrb_bank, its checker and the page model compiled before.
 */
`timescale 1ns/100ps
`default_nettype none
module switch_global_register_bank_tb;
  logic                mclk = 1'b0;
  logic                reset_n = 1'b0;
  sgrb_pkg::sgrb_req_s mreq = '0;
  logic                rv, ext_wr, ext_rd, dp_rst, irq_p, pin_o, pin_oe;
  logic [7:0]          rdata, ext_wdata, ext_rdata;
  logic [15:0]         ext_addr;
  logic                lk = 1'b0, gp = 1'b0, wk = 1'b0;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  logic [15:0]         rsv_a [7] = '{16'h0004, 16'h0600, 16'h0fff, 16'h1200, 16'h77ff,
                                     16'h1d00, 16'h7f00};
  always #2 mclk = ~mclk;
  sgrb_bank uut (.mclk(mclk), .reset_n(reset_n), .mgmt_req(mreq), .mgmt_rvalid(rv),
    .mgmt_rdata(rdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .datapath_rst(dp_rst),
    .lookup_engine_irq(lk), .gpio_ts_irq(gp), .irq_pending(irq_p),
    .wake_event_pin_o(pin_o), .wake_event_pin_oe(pin_oe), .wake_event(wk));
  sgrb_page_model u_pages (.mclk(mclk), .ext_wr(ext_wr), .ext_rd(ext_rd),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  task automatic stop_test;
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // one-cycle request, then idle one cycle so strobes never merge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 mreq = {1'b1, 1'b0, a, d};
    @(posedge mclk);
    #1 mreq = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    int n;
    @(posedge mclk);
    #1 mreq = {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    #1 mreq = '0;
    for (n = 0; n < 4 && rv !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n == 4) begin
      error_cnt++;
      stop_test();
    end
    chk(rdata, e);
  endtask
  task automatic wait3;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk(8'(pin_oe), 8'h00);
    chk(8'(pin_o), 8'h01);
    wait3();
    rd(16'h0000, sgrb_pkg::IDENT_FIXED_DEF);
    rd(16'h0001, sgrb_pkg::IDENT_UPPER_DEF);
    rd(16'h0002, sgrb_pkg::IDENT_LOWER_DEF);
    rd(16'h0003, {sgrb_pkg::REVISION_DEF, 4'h0});
    rd(16'h0006, 8'h00);
    rd(16'h0014, 8'h00);
    wr(16'h0001, 8'hff);
    rd(16'h0001, sgrb_pkg::IDENT_UPPER_DEF);
    foreach (rsv_a[i]) rd(rsv_a[i], 8'h00);
    wr(16'h0003, 8'h01);
    chk(8'(dp_rst), 8'h01);
    rd(16'h0003, {sgrb_pkg::REVISION_DEF, 4'h0});
    wr(16'h1420, 8'ha5);
    wr(16'h0105, 8'h3c);
    rd(16'h1420, 8'ha5);
    rd(16'h0105, 8'h3c);
    wr(16'h0006, 8'h02);
    // pin enable flop follows the control bit one edge later
    @(posedge mclk);
    #1;
    chk(8'(pin_oe), 8'h01);
    wk = 1'b1;
    wait3();
    chk(8'(pin_o), 8'h00);
    wr(16'h0006, 8'h03);
    wait3();
    chk(8'(pin_o), 8'h01);
    rd(16'h0006, 8'h03);
    lk = 1'b1;
    wait3();
    chk(8'(irq_p), 8'h01);
    rd(16'h0010, 8'h80);
    rd(16'h0010, 8'h80);
    rd(16'h0013, 8'h00);
    wr(16'h0014, 8'h80);
    wait3();
    chk(8'(irq_p), 8'h00);
    rd(16'h0014, 8'h80);
    gp = 1'b1;
    lk = 1'b0;
    wait3();
    chk(8'(irq_p), 8'h01);
    rd(16'h0010, 8'h40);
    wr(16'h0006, 8'h00);
    @(posedge mclk);
    #1;
    chk(8'(pin_oe), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
